// File: rtc_status_and_alarm_flags_tb_top.sv
// Self-checking bench for the status and alarm flag block.
// Assumes the host model drives the bus; the bench drives time and detectors.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module rtc_status_and_alarm_flags_tb_top
    import rtcsf_pkg::*;
;
    localparam int MC = 5;
    localparam logic [7:0] A_ST = {2'b00, RTCSF_IDX_STATUS, 2'b00};
    localparam logic [7:0] A_C1 = {2'b00, RTCSF_IDX_CTRL1, 2'b00};
    localparam logic [7:0] A_OFS = {2'b00, RTCSF_IDX_OFFSET, 2'b00};
    localparam logic [7:0] A_AM = {2'b00, RTCSF_IDX_ALARM, 2'b00};
    localparam logic [7:0] A_IST = {2'b00, RTCSF_IDX_IRQ_STAT, 2'b00};
    localparam logic [7:0] A_MSK = {2'b00, RTCSF_IDX_IRQ_MASK, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] det = 5'h00;
    logic [15:0] tm = 16'h0000;
    logic [RTCSF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic irq_out_first_n_o, irq_out_first_n_oe, irq_out_second_n_o, irq_out_second_n_oe;
    logic [7:0] cur, v;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    // ****************************************
    // Design, host model and clock
    // ****************************************
    rtcsf_top #(.MATCH_CYCLES(MC)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .current_hour_minute(tm),
        .power_on_detect(det[0]), .supply_drop_detect(det[1]), .osc_stop_detect(det[2]),
        .periodic_event(det[3]), .weekly_event(det[4]), .irq_out_first_n_o,
        .irq_out_first_n_oe, .irq_out_second_n_o, .irq_out_second_n_oe, .irq);
    rtcsf_host host_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    // Hang guard
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            test_done();
        end
    end
    // ****************************************
    // Helpers
    // ****************************************
    // Status after a write: flags clear on 0, oscillator flag sets on 1
    function automatic logic [7:0] st_wr(input logic [7:0] c, input logic [7:0] w);
        return (c & w & 8'h57) | ((c | w) & 8'h20) | (w & 8'h88);
    endfunction
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d, r);
        `CHK(d, {24'h00_0000, e})
        `CHK(r, RTCSF_RESP_OKAY)
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] e);
        host_u.wr(a, {24'h00_0000, e}, r);
        `CHK(r, RTCSF_RESP_OKAY)
    endtask
    task automatic pulse(input logic [4:0] m);
        @(posedge aclk) det <= m;
        repeat (4) @(posedge aclk);
        det <= 5'h00;
        repeat (6) @(posedge aclk);
    endtask
    task automatic set_tm(input logic [15:0] t);
        @(posedge aclk) tm <= t;
        repeat (3) @(posedge aclk);
    endtask
    // Drive a matching time and count edges until the first pin pulls low
    task automatic alarm_at(input logic [15:0] t);
        int n;
        @(posedge aclk) tm <= t;
        n = 0;
        while (irq_out_first_n_oe !== 1'b1 && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        `CHK(n >= MC + 1 && n <= MC + 4, 1'b1)
    endtask
    task automatic test_done;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        void'($urandom(32'h62b2_cfc3));
        rchk(A_ST, 8'h10);
        `CHK({irq_out_first_n_oe, irq_out_second_n_oe}, 2'b00)
        wreg(A_C1, 8'h40);
        wreg(A_OFS, 8'h55);
        rchk(A_C1, 8'h00);
        rchk(A_OFS, 8'h00);
        wreg(A_ST, 8'h10);
        rchk(A_ST, 8'h10);
        wreg(A_ST, 8'h00);
        rchk(A_ST, 8'h00);
        cur = 8'h00;
        $display("test reset done");
        host_u.slow = 3;
        repeat (6)
        begin
            v = 8'($urandom);
            wreg(A_OFS, v);
            rchk(A_OFS, v & RTCSF_OFFSET_MASK);
            v = 8'($urandom);
            wreg(A_ST, v);
            cur = st_wr(cur, v);
            rchk(A_ST, cur);
        end
        host_u.slow = 0;
        pulse(5'b11110);
        cur = (cur | 8'h46) & 8'hdf;
        rchk(A_ST, cur);
        `CHK(irq_out_second_n_oe, 1'b1)
        wreg(A_ST, 8'h20);
        cur = st_wr(cur, 8'h20);
        rchk(A_ST, cur);
        `CHK(irq_out_second_n_oe, 1'b0)
        host_u.rd(8'h40, d, r);
        `CHK({r, d}, {RTCSF_RESP_SLVERR, 32'h0000_0000})
        host_u.wr(8'h3d, 32'hffff_ffff, r);
        `CHK(r, RTCSF_RESP_SLVERR)
        rchk(A_ST, cur);
        $display("test registers done");
        wreg(A_AM, 8'h30);
        wreg(A_AM + 8'h04, 8'h12);
        wreg(A_MSK, 8'h01);
        wreg(A_C1, 8'h40);
        alarm_at(16'h1230);
        rchk(A_ST, cur | 8'h01);
        `CHK(irq, 1'b1)
        wreg(A_ST, cur | 8'h01);
        rchk(A_ST, cur | 8'h01);
        wreg(A_MSK, 8'h00);
        `CHK(irq, 1'b0)
        wreg(A_MSK, 8'h01);
        wreg(A_IST, 8'h01);
        `CHK(irq, 1'b0)
        wreg(A_ST, cur);
        `CHK(irq_out_first_n_oe, 1'b0)
        rchk(A_ST, cur);
        set_tm(16'h1231);
        alarm_at(16'h1230);
        wreg(A_C1, 8'h00);
        rchk(A_ST, cur);
        `CHK(irq_out_first_n_oe, 1'b0)
        wreg(A_ST, cur);
        set_tm(16'h1231);
        set_tm(16'h1230);
        repeat (MC + 6) @(posedge aclk);
        set_tm(16'h0000);
        wreg(A_C1, 8'h40);
        rchk(A_ST, cur);
        $display("test alarm done");
        alarm_at(16'h1230);
        pulse(5'b00001);
        rchk(A_ST, 8'h10 | (cur & 8'h20));
        rchk(A_C1, 8'h00);
        rchk(A_OFS, 8'h00);
        `CHK({irq_out_first_n_oe, irq_out_second_n_oe}, 2'b00)
        $display("test power-on done");
        test_done();
    end
endmodule

// File: rtcsf_delay.sv
// Delay counter that fires a one-cycle pulse a fixed time after a start.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps
module rtcsf_delay
    import rtcsf_pkg::*;
#(
    parameter int CYCLES = RTCSF_MATCH_DELAY_CYC
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic start,
    input wire logic cancel,
    output logic fire
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_fire;
    // Countdown decode
    assign next_count = cancel ? '0 : start ? LOAD : (count != '0) ? count - ONE : count;
    assign next_fire = !cancel && !start && (count == ONE);
    // Counter and pulse
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count <= '0;
            fire <= 1'b0;
        end
        else
        begin
            count <= next_count;
            fire <= next_fire;
        end
    end
endmodule

// File: rtcsf_host.sv
// Host controller model: an AXI4-Lite master with one write and one read task.
// Assumes the slave answers in its own time; slow delays bready and rready.
`timescale 1ns/100ps
module rtcsf_host
    import rtcsf_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Write channels
    output logic [RTCSF_ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [RTCSF_ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    int slow = 0;
    // Idle bus at time zero
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // Write: offer address and data together, release each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit pa;
        bit pw;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        pa = 1;
        pw = 1;
        while (pa || pw)
        begin
            @(posedge aclk);
            if (pa && s_axi_awready)
            begin
                pa = 0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a; // Released lines show no stale value
            end
            if (pw && s_axi_wready)
            begin
                pw = 0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        repeat (slow) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // Read: hold the address until taken, then wait for the data
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        repeat (slow) @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// File: rtcsf_pkg.sv
// Constants for the RTC status and alarm flag block.
// Assumes an AXI4-Lite register bus with 32-bit data and a 50 MHz clock.
package rtcsf_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] RTCSF_IDX_OFFSET = 4'h7;
    localparam logic [3:0] RTCSF_IDX_CTRL1 = 4'hE;
    localparam logic [3:0] RTCSF_IDX_STATUS = 4'hF;
    localparam logic [3:0] RTCSF_IDX_ALARM = 4'h8;
    localparam logic [3:0] RTCSF_IDX_TIME = 4'h9;
    localparam logic [3:0] RTCSF_IDX_IRQ_STAT = 4'hA;
    localparam logic [3:0] RTCSF_IDX_IRQ_MASK = 4'hB;
    localparam int RTCSF_ADDR_W = 8;
    // ****************************************
    // Status, control and offset register fields
    // ****************************************
    localparam int RTCSF_B_ALARM_FLAG = 0;
    localparam int RTCSF_B_WEEKLY = 1;
    localparam int RTCSF_B_PERIODIC = 2;
    localparam int RTCSF_B_CLKOUT_N = 3;
    localparam int RTCSF_B_PON = 4;
    localparam int RTCSF_B_OSC_N = 5;
    localparam int RTCSF_B_DROP = 6;
    localparam int RTCSF_B_THRESH = 7;
    localparam int RTCSF_B_CTRL1_ALARM_EN = 6;
    localparam logic [7:0] RTCSF_OFFSET_MASK = 8'h7f;
    localparam logic [7:0] RTCSF_ZERO8 = 8'h00;
    // Interrupt status bits
    localparam int RTCSF_IRQ_ALARM = 0;
    localparam int RTCSF_IRQ_PON = 1;
    // ****************************************
    // Timing
    // ****************************************
    localparam int RTCSF_CLK_HZ = 50_000_000;
    localparam int RTCSF_MATCH_DELAY_NS = 61_000;
    localparam int RTCSF_MATCH_DELAY_CYC = (RTCSF_MATCH_DELAY_NS * (RTCSF_CLK_HZ / 1_000_000)
        + 999) / 1000;
    // AXI responses
    localparam logic [1:0] RTCSF_RESP_OKAY = 2'b00;
    localparam logic [1:0] RTCSF_RESP_SLVERR = 2'b10;
endpackage

// File: rtcsf_top.sv
// Status and alarm flag logic of an RTC second control register.
// Assumes an AXI4-Lite master, and detector inputs from other clock domains.
`timescale 1ns/100ps
module rtcsf_top
    import rtcsf_pkg::*;
#(
    parameter int MATCH_CYCLES = RTCSF_MATCH_DELAY_CYC
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [RTCSF_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [RTCSF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timekeeping and detectors
    input wire logic [15:0] current_hour_minute,
    input wire logic power_on_detect,
    input wire logic supply_drop_detect,
    input wire logic osc_stop_detect,
    input wire logic periodic_event,
    input wire logic weekly_event,
    // Interrupt pins, open drain, and irq from masked interrupt status
    output logic irq_out_first_n_o,
    output logic irq_out_first_n_oe,
    output logic irq_out_second_n_o,
    output logic irq_out_second_n_oe,
    output logic irq
);
    // ****************************************
    // Synchronisers
    // ****************************************
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic [4:0] sync_prev;
    logic pon_pin;
    logic drop_pin;
    logic osc_pin;
    logic per_pin;
    logic week_pin;
    // Two-stage sampling of pin inputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a <= 5'h0;
            sync_b <= 5'h0;
            sync_prev <= 5'h0;
        end
        else
        begin
            sync_a <= {weekly_event, periodic_event, osc_stop_detect, supply_drop_detect,
                power_on_detect};
            sync_b <= sync_a;
            sync_prev <= sync_b;
        end
    end
    // Rising edges after synchronisation
    assign pon_pin = sync_b[0] && !sync_prev[0];
    assign drop_pin = sync_b[1] && !sync_prev[1];
    assign osc_pin = sync_b[2] && !sync_prev[2];
    assign per_pin = sync_b[3] && !sync_prev[3];
    assign week_pin = sync_b[4] && !sync_prev[4];

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] offset_reg;
    logic [7:0] ctrl1;
    logic thresh_sel;
    logic drop_flag;
    logic osc_stop_flag_n;
    logic power_on_flag;
    logic clkout_enable_first_n;
    logic periodic_irq_flag;
    logic weekly_alarm_flag;
    logic hour_minute_alarm_flag;
    logic [15:0] alarm_hour_minute;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic hour_minute_alarm_enable;
    assign hour_minute_alarm_enable = ctrl1[RTCSF_B_CTRL1_ALARM_EN];

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_held;
    logic w_held;
    logic [RTCSF_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [3:0] wr_idx;
    logic wr_ok;
    logic wr_lane0;
    logic [7:0] wb;
    logic rd_fire;
    logic [3:0] rd_idx;
    logic rd_ok;
    logic [7:0] rd_byte;
    logic [7:0] status_read;

    // Decode word index and legality of an address
    function automatic logic addr_ok(input logic [RTCSF_ADDR_W-1:0] a);
        logic [3:0] i;
        i = a[5:2];
        addr_ok = (a[RTCSF_ADDR_W-1:6] == '0) && (a[1:0] == 2'b00) &&
            (i == RTCSF_IDX_OFFSET || i == RTCSF_IDX_CTRL1 || i == RTCSF_IDX_STATUS ||
             i == RTCSF_IDX_ALARM || i == RTCSF_IDX_TIME || i == RTCSF_IDX_IRQ_STAT ||
             i == RTCSF_IDX_IRQ_MASK);
    endfunction

    // Channel handshakes
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx = aw_addr[5:2];
    assign wr_ok = addr_ok(aw_addr);
    assign wr_lane0 = wr_fire && wr_ok && w_strb[0];
    assign wb = w_data[7:0];
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[5:2];
    assign rd_ok = addr_ok(s_axi_araddr);

    // Hold address and data until both arrived
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RTCSF_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RTCSF_RESP_OKAY : RTCSF_RESP_SLVERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Status read view; alarm flag masked by enable
    assign status_read = {thresh_sel, drop_flag, osc_stop_flag_n, power_on_flag,
        clkout_enable_first_n, periodic_irq_flag, weekly_alarm_flag,
        hour_minute_alarm_flag && hour_minute_alarm_enable};
    // Read multiplexer; unused upper bits read zero
    assign rd_byte = (rd_idx == RTCSF_IDX_OFFSET) ? (offset_reg & RTCSF_OFFSET_MASK) :
        (rd_idx == RTCSF_IDX_CTRL1) ? ctrl1 :
        (rd_idx == RTCSF_IDX_STATUS) ? status_read :
        (rd_idx == RTCSF_IDX_ALARM) ? alarm_hour_minute[7:0] :
        (rd_idx == RTCSF_IDX_TIME) ? alarm_hour_minute[15:8] :
        (rd_idx == RTCSF_IDX_IRQ_STAT) ? {6'h00, irq_stat} :
        (rd_idx == RTCSF_IDX_IRQ_MASK) ? {6'h00, irq_mask} : RTCSF_ZERO8;

    // Read response register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RTCSF_RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            s_axi_rresp <= rd_ok ? RTCSF_RESP_OKAY : RTCSF_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // Alarm comparison
    // ****************************************
    logic match_now;
    logic match_prev;
    logic match_rise;
    logic alarm_fire;
    // Compare only while enabled, once per new match
    assign match_now = hour_minute_alarm_enable &&
        (current_hour_minute == alarm_hour_minute);
    assign match_rise = match_now && !match_prev;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            match_prev <= 1'b0;
        end
        else
        begin
            match_prev <= match_now;
        end
    end

    // Flag set a fixed delay after the match
    rtcsf_delay #(
        .CYCLES(MATCH_CYCLES)
    ) u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(match_rise),
        .cancel(!hour_minute_alarm_enable || power_on_flag),
        .fire(alarm_fire)
    );

    // ****************************************
    // Flag and control register updates
    // ****************************************
    logic st_wr;
    logic [7:0] next_status_w;
    assign st_wr = wr_lane0 && (wr_idx == RTCSF_IDX_STATUS);

    // Flags other than the oscillator flag clear on zero and keep on one; a one sets the oscillator flag
    assign next_status_w = {wb[RTCSF_B_THRESH],
        drop_flag && wb[RTCSF_B_DROP],
        osc_stop_flag_n || wb[RTCSF_B_OSC_N],
        power_on_flag && wb[RTCSF_B_PON],
        wb[RTCSF_B_CLKOUT_N],
        periodic_irq_flag && wb[RTCSF_B_PERIODIC],
        weekly_alarm_flag && wb[RTCSF_B_WEEKLY],
        hour_minute_alarm_flag && wb[RTCSF_B_ALARM_FLAG]};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_on_flag <= 1'b1;
            osc_stop_flag_n <= 1'b0;
        end
        else
        begin
            power_on_flag <= pon_pin || (st_wr ? next_status_w[RTCSF_B_PON] :
                power_on_flag);
            osc_stop_flag_n <= !osc_pin && (st_wr ? next_status_w[RTCSF_B_OSC_N] :
                osc_stop_flag_n);
        end
    end

    // Registers cleared while power-on flag is set
    always_ff @(posedge aclk)
    begin
        if (!aresetn || power_on_flag)
        begin
            offset_reg <= RTCSF_ZERO8;
            ctrl1 <= RTCSF_ZERO8;
            thresh_sel <= 1'b0;
            drop_flag <= 1'b0;
            clkout_enable_first_n <= 1'b0;
            periodic_irq_flag <= 1'b0;
            weekly_alarm_flag <= 1'b0;
            hour_minute_alarm_flag <= 1'b0;
        end
        else
        begin
            if (wr_lane0 && wr_idx == RTCSF_IDX_OFFSET)
                offset_reg <= wb & RTCSF_OFFSET_MASK;
            if (wr_lane0 && wr_idx == RTCSF_IDX_CTRL1)
                ctrl1 <= wb;
            if (st_wr)
            begin
                thresh_sel <= next_status_w[RTCSF_B_THRESH];
                clkout_enable_first_n <= next_status_w[RTCSF_B_CLKOUT_N];
            end
            drop_flag <= drop_pin || (st_wr ? next_status_w[RTCSF_B_DROP] : drop_flag);
            periodic_irq_flag <= per_pin ||
                (st_wr ? next_status_w[RTCSF_B_PERIODIC] : periodic_irq_flag);
            weekly_alarm_flag <= week_pin ||
                (st_wr ? next_status_w[RTCSF_B_WEEKLY] : weekly_alarm_flag);
            hour_minute_alarm_flag <= alarm_fire || (st_wr ?
                next_status_w[RTCSF_B_ALARM_FLAG] : hour_minute_alarm_flag);
        end
    end

    // Alarm time register and interrupt controller
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alarm_hour_minute <= 16'h0000;
            irq_stat <= 2'b00;
            irq_mask <= 2'b00;
        end
        else
        begin
            if (wr_lane0 && wr_idx == RTCSF_IDX_ALARM)
                alarm_hour_minute[7:0] <= wb;
            if (wr_lane0 && wr_idx == RTCSF_IDX_TIME)
                alarm_hour_minute[15:8] <= wb;
            if (wr_lane0 && wr_idx == RTCSF_IDX_IRQ_MASK)
                irq_mask <= wb[1:0];
            irq_stat[RTCSF_IRQ_ALARM] <= alarm_fire || (irq_stat[RTCSF_IRQ_ALARM] &&
                !(wr_lane0 && wr_idx == RTCSF_IDX_IRQ_STAT && wb[RTCSF_IRQ_ALARM]));
            irq_stat[RTCSF_IRQ_PON] <= pon_pin || (irq_stat[RTCSF_IRQ_PON] &&
                !(wr_lane0 && wr_idx == RTCSF_IDX_IRQ_STAT && wb[RTCSF_IRQ_PON]));
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open-drain pins pull low only while a flag asks for it
    assign irq_out_first_n_o = 1'b0;
    assign irq_out_first_n_oe = !power_on_flag && hour_minute_alarm_enable &&
        (hour_minute_alarm_flag || periodic_irq_flag);
    assign irq_out_second_n_o = 1'b0;
    assign irq_out_second_n_oe = !power_on_flag && weekly_alarm_flag;
    assign irq = |(irq_stat & irq_mask);
endmodule

// File: rtcsf_top_props.sv
// Concurrent checks on the ports of the status and alarm flag block.
// Assumes a single clock domain with aresetn as its synchronous reset.
`timescale 1ns/100ps
module rtcsf_top_props
    import rtcsf_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [RTCSF_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Detector and pins
    input wire logic power_on_detect,
    input wire logic irq_out_first_n_o,
    input wire logic irq_out_first_n_oe,
    input wire logic irq_out_second_n_o,
    input wire logic irq_out_second_n_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshake steps and released-pin state
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_pins_off;
        !irq_out_first_n_oe && !irq_out_second_n_oe;
    endsequence
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered one cycle after it was taken");
    // Both halves held at the taking edge, commit and bvalid at the next one
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write not answered two cycles after it was taken");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before it was accepted");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before it was accepted");
    a_ar_ready: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready not the inverse of read valid");
    a_unmapped_err: assert property (s_rd_taken ##0 (s_axi_araddr >= 8'h40) |=>
        s_axi_rresp == RTCSF_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_reset_quiet: assert property ($rose(aresetn) |-> s_pins_off)
        else $error("interrupt pin driven right after reset");
    a_pon_release: assert property ($rose(power_on_detect) |-> ##[1:6] s_pins_off)
        else $error("interrupt pins not released after power-on detection");
    a_pins_low_only: assert property (!irq_out_first_n_o && !irq_out_second_n_o)
        else $error("open-drain pin driven high");
endmodule
bind rtcsf_top rtcsf_top_props props_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .power_on_detect, .irq_out_first_n_o, .irq_out_first_n_oe, .irq_out_second_n_o,
    .irq_out_second_n_oe);
